// File: logic/sam_pkg.sv
package sam_pkg;
	// ============================================================
	// widths
	localparam int RESULT_W = 8;
	localparam int CHAN_W = 3;
	localparam int CHAN_N = 8;
	// ============================================================
	// timing
	localparam int CLK_PERIOD_NS = 5;
	localparam int STROBE_MIN_NS = 200;
	localparam int SETTLE_MAX_NS = 2500;
	localparam int OE_MAX_NS = 250;
	localparam int CONV_CLK_KHZ = 640;
	localparam int MCLK_KHZ = 200000;
	localparam int STROBE_CYCLES = (STROBE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_CYCLES = (SETTLE_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int OE_WAIT_CYCLES = (OE_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CONV_DIV = MCLK_KHZ / CONV_CLK_KHZ;
	localparam int TICKS_PER_TRIAL = 8;
	// ============================================================
	// reset, seed and end values
	localparam logic [RESULT_W-1:0] RESULT_RST = 8'h00;
	localparam logic [CHAN_W-1:0] CHAN_RST = 3'h0;
	localparam logic [RESULT_W-1:0] TRIAL_MSB = 8'h80;
	localparam logic [CHAN_W-1:0] BIT_TOP = 3'h7;
	localparam logic [2:0] TICK_LAST = 3'(TICKS_PER_TRIAL - 1);
endpackage

// File: logic/sam_link_if.sv
interface sam_link_if;
	import sam_pkg::*;
	logic [CHAN_W-1:0] addr;
	logic ale;
	logic start;
	logic oe_req;
	logic done;
	logic [RESULT_W-1:0] result_q;
	logic result_oe;
	wire [RESULT_W-1:0] result_bus;
	// ============================================================
	// released bus reads as pulled low
	assign result_bus = result_oe ? result_q : '0;
	modport dev (
		input addr,
		input ale,
		input start,
		input oe_req,
		output done,
		output result_q,
		output result_oe
	);
	modport host (
		output addr,
		output ale,
		output start,
		output oe_req,
		input done,
		input result_bus
	);
endinterface

// File: logic/sam_device.sv
// Behaviour
// - latch channel code on strobe rising edge
// - code selects input zero to seven binary
// - eight trials, msb first, one per bit
// - convert strobe rise clears approximation register
// - conversion starts on convert strobe fall
// - new strobe aborts run, no result
// - done looped to strobe gives free running
// - host kicks free running once after start
// - done drops within eight periods after rise
// - result loaded one period before done rises
// - result is positive-true binary
// - convert strobe high at least 200 ns
// - address strobe high at least 200 ns
// - host waits 2.5 us after channel change
// - result driven only while enable asserted
module sam_device #(
	parameter int DIV = sam_pkg::CONV_DIV
) (
	input wire logic mclk,
	input wire logic resetn,
	sam_link_if.dev link,
	output logic [sam_pkg::CHAN_N-1:0] selected_channel,
	output logic [sam_pkg::RESULT_W-1:0] trial_word,
	input wire logic compare_high
);
	import sam_pkg::*;

	localparam int DIV_W = $clog2(DIV + 1);
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIV - 1);
	localparam logic [2:0] BIT_LAST = 3'h0;

	// ============================================================
	// state
	typedef struct packed {
		// strobe history for edge detection
		logic ale_q;
		logic start_q;
		// latched channel code and its one-hot decode
		logic [CHAN_W-1:0] chan;
		logic [CHAN_N-1:0] select;
		// approximation word and the held result
		logic [RESULT_W-1:0] successive_approx_register;
		logic [RESULT_W-1:0] result;
		// sequencer position
		logic running;
		logic [2:0] bit_idx;
		logic [2:0] tick_cnt;
		// conversion clock divider
		logic [DIV_W-1:0] div_cnt;
		logic tick;
		// done handshake
		logic done;
		logic done_drop;
		logic done_arm;
		// result drive enable
		logic oe;
	} sam_dev_st_t;

	sam_dev_st_t s;
	sam_dev_st_t next_s;

	// ============================================================
	// next state
	always_comb begin
		logic ale_rise;
		logic start_rise;
		logic start_fall;
		logic seq_step;
		logic trial_end;
		logic last_bit;
		logic conv_end;

		ale_rise = link.ale && !s.ale_q;
		start_rise = link.start && !s.start_q;
		start_fall = !link.start && s.start_q;
		// a convert strobe edge always outranks a trial step
		seq_step = s.running && s.tick && !start_rise && !start_fall;
		trial_end = seq_step && (s.tick_cnt == TICK_LAST);
		last_bit = (s.bit_idx == BIT_LAST);
		conv_end = trial_end && last_bit;
		next_s = s;

		// ============================================================
		// conversion clock as a one-cycle enable
		next_s.tick = (s.div_cnt == DIV_LAST);
		if (s.div_cnt == DIV_LAST) begin
			next_s.div_cnt = '0;
		end else begin
			next_s.div_cnt = DIV_W'(s.div_cnt + 1'b1);
		end

		// strobe history
		next_s.ale_q = link.ale;
		next_s.start_q = link.start;

		// drive enable follows the request one cycle late
		next_s.oe = link.oe_req;

		// ============================================================
		// channel code holds until the next address strobe rise
		if (ale_rise) begin
			next_s.chan = link.addr;
		end
		for (int i = 0; i < CHAN_N; i++) begin
			next_s.select[i] = (next_s.chan == CHAN_W'(i));
		end

		// ============================================================
		// approximation register: a rise clears, the fall seeds the msb
		if (start_rise) begin
			next_s.successive_approx_register = RESULT_RST;
		end else if (start_fall) begin
			next_s.successive_approx_register = TRIAL_MSB;
		end else if (trial_end) begin
			// high comparator keeps a one, positive true
			next_s.successive_approx_register[s.bit_idx] = compare_high;
			if (!last_bit) begin
				next_s.successive_approx_register[3'(s.bit_idx - 1'b1)] = 1'b1;
			end
		end

		// run flag
		if (start_rise) begin
			next_s.running = 1'b0;
		end else if (start_fall) begin
			next_s.running = 1'b1;
		end else if (conv_end) begin
			next_s.running = 1'b0;
		end

		// bit pointer, msb first
		if (start_fall) begin
			next_s.bit_idx = BIT_TOP;
		end else if (trial_end && !last_bit) begin
			next_s.bit_idx = 3'(s.bit_idx - 1'b1);
		end

		// ticks within one trial
		// limitation: the comparator is looked at only on the last tick
		if (start_fall) begin
			next_s.tick_cnt = 3'h0;
		end else if (seq_step) begin
			next_s.tick_cnt = 3'(s.tick_cnt + 1'b1);
		end

		// result only from a run that reached its last bit
		if (conv_end) begin
			next_s.result = next_s.successive_approx_register;
		end

		// ============================================================
		// done handshake
		// pending drop: set by a strobe rise, served on a tick; set wins
		if (start_rise) begin
			next_s.done_drop = 1'b1;
		end else if (s.tick) begin
			next_s.done_drop = 1'b0;
		end

		// arm: abort drops any pending result
		if (start_rise) begin
			next_s.done_arm = 1'b0;
		end else if (conv_end) begin
			next_s.done_arm = 1'b1;
		end else if (s.tick && !s.done_drop) begin
			next_s.done_arm = 1'b0;
		end

		// done moves on ticks only: drop within one period
		if (s.tick && s.done_drop) begin
			next_s.done = 1'b0;
		end else if (s.tick && s.done_arm && !start_rise) begin
			// result already stable one period earlier
			next_s.done = 1'b1;
		end
	end

	// ============================================================
	// state register
	// synchronous reset; divider restarts at zero
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ============================================================
	// link outputs
	// done fed back as strobe: rise clears, fall restarts
	assign link.done = s.done;
	assign link.result_q = s.result;
	assign link.result_oe = s.oe;

	// ============================================================
	// observation outputs
	assign selected_channel = s.select;
	assign trial_word = s.successive_approx_register;
endmodule

// File: logic/sam_host.sv
module sam_host (
	input wire logic mclk,
	input wire logic resetn,
	sam_link_if.host link,
	input wire logic select_req,
	input wire logic [sam_pkg::CHAN_W-1:0] select_chan,
	input wire logic convert_req,
	input wire logic free_run,
	output logic host_ready,
	output logic [sam_pkg::RESULT_W-1:0] sample_data,
	output logic sample_valid
);
	import sam_pkg::*;

	typedef enum logic [2:0] {
		H_IDLE,
		H_ALE,
		H_SETTLE,
		H_START,
		H_READ
	} sam_hstate_t;

	typedef struct packed {
		sam_hstate_t st;
		logic [9:0] cnt;
		logic [CHAN_W-1:0] addr;
		logic ale;
		logic start;
		logic oe;
		logic done_q;
		logic fr_q;
		logic ready;
		logic [RESULT_W-1:0] data;
		logic valid;
	} sam_host_st_t;

	sam_host_st_t s;
	sam_host_st_t next_s;

	// ============================================================
	// next state
	always_comb begin
		next_s = s;
		next_s.valid = 1'b0;
		next_s.done_q = link.done;
		next_s.fr_q = free_run;
		next_s.cnt = 10'(s.cnt + 1'b1);
		case (s.st)
			H_IDLE: begin
				next_s.cnt = 10'h000;
				if (free_run && !s.fr_q) begin
					next_s.st = H_START;
				end else if (link.done && !s.done_q) begin
					next_s.st = H_READ;
					next_s.oe = 1'b1;
				end else if (select_req) begin
					next_s.st = H_ALE;
					next_s.addr = select_chan;
					next_s.ale = 1'b1;
				end else if (convert_req && !free_run) begin
					next_s.st = H_START;
				end
			end
			H_ALE: begin
				if (s.cnt == 10'(STROBE_CYCLES - 1)) begin
					next_s.ale = 1'b0;
					next_s.st = H_SETTLE;
					next_s.cnt = 10'h000;
				end
			end
			H_SETTLE: begin
				// mux not trusted until settled
				if (s.cnt == 10'(SETTLE_CYCLES - 1)) begin
					next_s.st = H_IDLE;
				end
			end
			H_START: begin
				if (s.cnt == 10'(STROBE_CYCLES - 1)) begin
					next_s.st = H_IDLE;
				end
			end
			H_READ: begin
				if (s.cnt == 10'(OE_WAIT_CYCLES - 1)) begin
					next_s.data = link.result_bus;
					next_s.valid = 1'b1;
					next_s.oe = 1'b0;
					next_s.st = H_IDLE;
				end
			end
			default: begin
				next_s.st = H_IDLE;
			end
		endcase
		// loop done back as the strobe outside the kick pulse
		if (next_s.st == H_START) begin
			next_s.start = 1'b1;
		end else if (free_run) begin
			next_s.start = link.done;
		end else begin
			next_s.start = 1'b0;
		end
		next_s.ready = (next_s.st == H_IDLE);
	end

	// ============================================================
	// state register
	always_ff @(posedge mclk) begin
		if (!resetn) begin
			s <= '{st: H_IDLE, ready: 1'b0, default: '0};
		end else begin
			s <= next_s;
		end
	end

	assign link.addr = s.addr;
	assign link.ale = s.ale;
	assign link.start = s.start;
	assign link.oe_req = s.oe;
	assign host_ready = s.ready;
	assign sample_data = s.data;
	assign sample_valid = s.valid;
endmodule

// File: dv/sam_chk_sva.sv
module sam_chk_sva
	import sam_pkg::*;
#(
	parameter int DIV = 40
) (
	input wire logic mclk,
	input wire logic resetn,
	input wire logic start,
	input wire logic oe_req,
	input wire logic done,
	input wire logic [RESULT_W-1:0] result_q,
	input wire logic result_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	// ============================================================
	// link checks
	localparam int DROP_MAX = DIV + 1;
	localparam int CONV_MIN = 63 * DIV;
	int cnt;
	// cycles since strobe low; first trial may be short, so one tick slack
	always_ff @(posedge mclk) cnt <= (!resetn || start) ? 0 : cnt + 1;
	default clocking @(posedge mclk); endclocking
	default disable iff (!resetn);
	property p_oe_on; $rose(oe_req) |=> result_oe; endproperty
	a_oe_on: assert property (p_oe_on) else $error("drive late");
	property p_oe_off; $fell(oe_req) |=> !result_oe; endproperty
	a_oe_off: assert property (p_oe_off) else $error("release late");
	property p_drop; $rose(start) && done |-> ##[1:DROP_MAX] !done; endproperty
	a_drop: assert property (p_drop) else $error("done drop late");
	property p_fall; $fell(done) |-> start || $past(start) || $past(start, 2); endproperty
	a_fall: assert property (p_fall) else $error("done fell unasked");
	property p_load; $changed(result_q) |-> !done ##[1:DROP_MAX] done; endproperty
	a_load: assert property (p_load) else $error("load order");
	property p_rise; $rose(done) |-> !start && cnt >= CONV_MIN; endproperty
	a_rise: assert property (p_rise) else $error("done early");
	property p_hold; done && !start |=> done; endproperty
	a_hold: assert property (p_hold) else $error("done lost");
	property p_stay; done |=> $stable(result_q); endproperty
	a_stay: assert property (p_stay) else $error("result moved");
endmodule

// File: dv/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import sam_pkg::*;
	localparam int DIV = 40;
	logic mclk = 0, resetn = 0, select_req = 0, convert_req = 0, free_run = 0;
	logic compare_high = 0, host_ready, sample_valid;
	logic [CHAN_W-1:0] select_chan = 3'h0;
	logic [RESULT_W-1:0] sample_data, trial_word, ana = 8'h00;
	logic [CHAN_N-1:0] selected_channel;
	logic [7:0] chan_val [8] = '{8'h00, 8'h01, 8'h80, 8'hff, 8'h55, 8'haa, 8'h7f, 8'hc3};
	int mismatches = 0, num_checks = 0, n_samp = 0;
	sam_link_if link();
	sam_device #(.DIV(DIV)) u_sam_device (.mclk(mclk), .resetn(resetn), .link(link),
		.selected_channel(selected_channel), .trial_word(trial_word),
		.compare_high(compare_high));
	sam_host u_sam_host (.mclk(mclk), .resetn(resetn), .link(link),
		.select_req(select_req), .select_chan(select_chan), .convert_req(convert_req),
		.free_run(free_run), .host_ready(host_ready), .sample_data(sample_data),
		.sample_valid(sample_valid));
	sam_chk_sva #(.DIV(DIV)) u_chk (.mclk(mclk), .resetn(resetn), .start(link.start),
		.oe_req(link.oe_req), .done(link.done), .result_q(link.result_q),
		.result_oe(link.result_oe));
	initial forever #2.5 mclk = ~mclk;
	// ============================================================
	// analog side: comparator follows the latched channel, not the request
	always @(posedge mclk) begin
		for (int i = 0; i < CHAN_N; i++) if (selected_channel[i]) ana <= chan_val[i];
		compare_high <= ana >= trial_word;
		if (sample_valid === 1'b1) n_samp <= n_samp + 1;
	end
	task check(string name, logic [7:0] seen, logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task tick(int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task wait_ready;
		for (int k = 0; k < 2000 && host_ready !== 1'b1; k++) tick(1);
	endtask
	task req_conv;
		wait_ready;
		@(posedge mclk) convert_req <= 1'b1;
		@(posedge mclk) convert_req <= 1'b0;
	endtask
	task get_sample;
		for (int k = 0; k < 256 * DIV && sample_valid !== 1'b1; k++) tick(1);
		check("valid", {7'h00, sample_valid}, 8'h01);
		tick(1);
	endtask
	task t_channels;
		for (int c = 0; c < CHAN_N; c++) begin
			wait_ready;
			@(posedge mclk) select_req <= 1'b1;
			select_chan <= 3'(c);
			@(posedge mclk) select_req <= 1'b0;
			tick(1);
			wait_ready;
			check("channel", selected_channel, 8'h01 << c);
			req_conv;
			get_sample;
			check("data", sample_data, chan_val[c]);
		end
		$display("test channels done");
	endtask
	task t_hold;
		tick(200);
		check("done", {7'h00, link.done}, 8'h01);
		check("bus", link.result_bus, 8'h00);
		check("result", link.result_q, 8'hc3);
		$display("test hold done");
	endtask
	task t_abort;
		int s;
		s = n_samp;
		req_conv;
		tick(20 * DIV);
		check("aborted", 8'(n_samp - s), 8'h00);
		req_conv;
		get_sample;
		tick(2);
		check("runs", 8'(n_samp - s), 8'h01);
		check("data", sample_data, 8'hc3);
		$display("test abort done");
	endtask
	task t_free;
		int s;
		s = n_samp;
		@(posedge mclk) free_run <= 1'b1;
		repeat (3) get_sample;
		tick(2);
		check("free runs", 8'(n_samp - s), 8'h03);
		check("data", sample_data, 8'hc3);
		$display("test free run done");
	endtask
	initial begin
		repeat (10) @(posedge mclk);
		resetn <= 1'b1;
		t_channels;
		t_hold;
		t_abort;
		t_free;
		end_sim;
	end
	// hang guard, about twice the expected run
	initial begin
		#400000;
		mismatches++;
		end_sim;
	end
endmodule
